//--- src/ubgls_dev.sv
// Serial port with rate generator, divider, timer 1 and LIN autobaud
`timescale 1ns/100ps
// Function
// - Full duplex, one-byte receive buffer, overrun
// - Eight or nine data bits, LSB first
// - Four modes: shift, 8-bit, 9-bit fixed/variable
// - Mode 2 rate is clock/32 or /64
// - Variable rate from generator or timer 1
// - Down timer clocked by divider or prescaler
// - Fractional mode: run bit starts rate timer
// - Underflow reloads and emits one tick
// - Normal divider mode stops rate timer
// - Prescaler divides by two to field
// - Step/256 factor only in fractional mode
// - Rate formula; factor product above one
// - Rate never above clock over 32, except mode 0 shift at clock/2
// - Timer 1 rate formula with doubling bit
// - Normal mode: up-counter from step, readable
// - Overflow sets flag, interrupt, 256-step division
// - Interrupt on transmit and receive completion
// - Measure incoming bit rate for LIN
// - LIN header: break, sync 55h, identifier
// - Break is at least 13 dominant bits; the detector accepts a low run of 11 bits (176 ticks)
// - Headers sent only when master
// - Resynchronise on every header
// - Timer 1 reloads low byte from high
module ubgls_dev (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  ubgls_link_if.dev       link,
  input  wire logic [1:0] mode,
  input  wire logic       rate_double_bit,
  input  wire logic       baud_src_timer1,
  input  wire logic       baud_timer_run,
  input  wire logic [2:0] baud_prescale_field,
  input  wire logic [7:0] baud_reload_value,
  input  wire logic       frac_div_enable,
  input  wire logic       frac_div_mode_select,
  input  wire logic [7:0] frac_div_increment_reg,
  output logic      [7:0] frac_div_count_reg,
  output logic            divider_overflow_flag,
  input  wire logic       divider_ovf_clear,
  output logic            divider_irq,
  input  wire logic       timer1_run,
  input  wire logic [7:0] timer1_high_byte,
  input  wire logic       tx_valid,
  input  wire logic [8:0] tx_data,
  output logic            tx_ready,
  input  wire logic       lin_master,
  input  wire logic       lin_break_req,
  output logic            tx_done_irq,
  input  wire logic       rx_enable,
  output logic      [8:0] rx_data,
  output logic            rx_full,
  input  wire logic       rx_read,
  output logic            rx_overrun,
  output logic            rx_done_irq,
  input  wire logic       lin_autobaud,
  output logic            lin_sync_done,
  output logic     [15:0] lin_bit_cycles
);
  typedef struct packed {
    logic [6:0]           pre;
    logic [7:0]           fd;
    logic                 fd_ovf;
    logic                 fd_irq;
    logic [7:0]           bt;
    logic                 lim;
    logic                 t1ph;
    logic [7:0]           t1lo;
    logic                 t1half;
    logic [1:0]           m2;
    ubgls_pkg::ubgls_tx_t txs;
    logic [3:0]           tovs;
    logic [3:0]           tbit;
    logic [13:0]          tsh;
    logic                 txd;
    logic                 sclk;
    logic                 ph;
    logic                 brk_pend;
    logic                 tx_irq;
    logic [7:0]           msh;
    ubgls_pkg::ubgls_rx_t rxs;
    logic [3:0]           rovs;
    logic [3:0]           rbit;
    logic [8:0]           rsh;
    logic                 rxd_p;
    logic [8:0]           rbuf;
    logic                 rfull;
    logic                 rovr;
    logic                 rx_irq;
    ubgls_pkg::ubgls_lin_t ls;
    logic [11:0]          low;
    logic [2:0]           edges;
    logic [18:0]          cyc;
    logic [15:0]          lbits;
    logic                 ldone;
  } ubgls_dev_st_t;

  function automatic logic [6:0] ubgls_pre_mask(input logic [2:0] f);
    ubgls_pre_mask = 7'((8'h01 << f) - 8'h01);
  endfunction

  ubgls_dev_st_t s_q, s_d;
  logic       prescaler_output_clock, divider_output_clock, normal_mode, bg_raw, t1_ovf, t1_tick, tick;
  logic       fifo_valid, fifo_take, nine, rxd, fall, rx_done;
  logic [8:0] fifo_data, rx_word;
  logic [8:0] frac_sum;

  ubgls_fifo #(.W(9), .DEPTH(16)) u_txq (
    .mclk    (mclk),
    .reset_n (reset_n),
    .s_valid (tx_valid),
    .s_data  (tx_data),
    .s_ready (tx_ready),
    .m_valid (fifo_valid),
    .m_data  (fifo_data),
    .m_ready (fifo_take)
  );

  always_comb begin
    s_d = s_q;
    rxd = link.h2d_txd;
    fall = s_q.rxd_p && !rxd;
    s_d.rxd_p = rxd;
    nine = mode[1];
    normal_mode = frac_div_enable && frac_div_mode_select;
    rx_done = 1'b0;
    rx_word = '0;
    s_d.fd_irq = 1'b0;
    s_d.tx_irq = 1'b0;
    s_d.ldone = 1'b0;
    prescaler_output_clock = (s_q.pre == ubgls_pre_mask(baud_prescale_field));
    s_d.pre = prescaler_output_clock ? 7'h00 : s_q.pre + 7'h01;
    frac_sum = {1'b0, s_q.fd} + {1'b0, frac_div_increment_reg};
    divider_output_clock = 1'b0;
    if (frac_div_enable && prescaler_output_clock) begin
      if (!frac_div_mode_select) begin
        s_d.fd = frac_sum[7:0];
        divider_output_clock = frac_sum[8];
      end else if (s_q.fd == ubgls_pkg::UBGLS_BYTE_MAX) begin
        s_d.fd = frac_div_increment_reg;
        s_d.fd_ovf = 1'b1;
        s_d.fd_irq = 1'b1;
      end else begin
        s_d.fd = s_q.fd + 8'h01;
      end
    end
    if (divider_ovf_clear && !s_d.fd_irq) begin
      s_d.fd_ovf = 1'b0;
    end
    bg_raw = 1'b0;
    if (baud_timer_run && !normal_mode &&
        (frac_div_enable ? divider_output_clock : prescaler_output_clock)) begin
      if (s_q.bt == 8'h00) begin
        s_d.bt = baud_reload_value;
        bg_raw = 1'b1;
      end else begin
        s_d.bt = s_q.bt - 8'h01;
      end
    end
    // timer 1 auto-reload, one count per two clocks
    t1_ovf = 1'b0;
    s_d.t1ph = timer1_run ? !s_q.t1ph : s_q.t1ph;
    if (timer1_run && s_q.t1ph) begin
      if (s_q.t1lo == ubgls_pkg::UBGLS_BYTE_MAX) begin
        s_d.t1lo = timer1_high_byte;
        t1_ovf = 1'b1;
      end else begin
        s_d.t1lo = s_q.t1lo + 8'h01;
      end
    end
    // doubling bit halves the overflow division
    if (t1_ovf) begin
      s_d.t1half = !s_q.t1half;
    end
    t1_tick = t1_ovf && (rate_double_bit || s_q.t1half);
    s_d.m2 = s_q.m2 + 2'h1;
    if (mode == ubgls_pkg::UBGLS_MODE2) begin
      tick = rate_double_bit ? s_q.m2[0] : (s_q.m2 == ubgls_pkg::UBGLS_M2_SLOW);
    end else begin
      tick = baud_src_timer1 ? t1_tick : bg_raw;
    end
    // no two ticks back to back
    // factor product of one is refused
    tick = tick && !s_q.lim;
    s_d.lim = tick;

    if (lin_break_req && lin_master) begin
      s_d.brk_pend = 1'b1;
    end
    fifo_take = 1'b0;
    case (s_q.txs)
      ubgls_pkg::UBGLS_TX_IDLE: begin
        s_d.tovs = 4'h0;
        s_d.ph = 1'b0;
        // Frames start on a tick, else the first bit runs short
        // 13 dominant bits then delimiter
        if (s_q.brk_pend && tick && mode != ubgls_pkg::UBGLS_MODE0) begin
          s_d.brk_pend = 1'b0;
          s_d.tsh = ubgls_pkg::UBGLS_BRK_PAT;
          s_d.tbit = ubgls_pkg::UBGLS_BRK_TOTAL;
          s_d.txs = ubgls_pkg::UBGLS_TX_FRAME;
        end else if (fifo_valid &&
                     (tick || mode == ubgls_pkg::UBGLS_MODE0)) begin
          fifo_take = 1'b1;
          // start bit then data LSB first
          s_d.tsh = nine ? {4'hf, fifo_data, 1'b0}
                         : {5'h1f, fifo_data[7:0], 1'b0};
          s_d.tbit = nine ? ubgls_pkg::UBGLS_BITS_9
                          : ubgls_pkg::UBGLS_BITS_8;
          if (mode == ubgls_pkg::UBGLS_MODE0) begin
            s_d.tsh = {6'h3f, fifo_data[7:0]};
            s_d.tbit = ubgls_pkg::UBGLS_BITS_M0;
            s_d.txs = ubgls_pkg::UBGLS_TX_SHIFT;
          end else begin
            s_d.txs = ubgls_pkg::UBGLS_TX_FRAME;
          end
        end
      end
      ubgls_pkg::UBGLS_TX_FRAME: begin
        if (tick) begin
          s_d.tovs = s_q.tovs + 4'h1;
          if (s_q.tovs == ubgls_pkg::UBGLS_OVS_LAST) begin
            s_d.tsh = {1'b1, s_q.tsh[13:1]};
            s_d.tbit = s_q.tbit - 4'h1;
            if (s_q.tbit == 4'h1) begin
              s_d.tx_irq = 1'b1;
              s_d.txs = ubgls_pkg::UBGLS_TX_IDLE;
            end
          end
        end
      end
      default: begin
        // mode 0 shifts one bit per two clocks
        s_d.ph = !s_q.ph;
        if (s_q.ph) begin
          s_d.msh = {rxd, s_q.msh[7:1]};
          s_d.tsh = {1'b1, s_q.tsh[13:1]};
          s_d.tbit = s_q.tbit - 4'h1;
          if (s_q.tbit == 4'h1) begin
            s_d.tx_irq = 1'b1;
            rx_done = 1'b1;
            rx_word = {1'b0, rxd, s_q.msh[7:1]};
            s_d.txs = ubgls_pkg::UBGLS_TX_IDLE;
          end
        end
      end
    endcase
    s_d.txd = (s_d.txs == ubgls_pkg::UBGLS_TX_IDLE) ? 1'b1 : s_d.tsh[0];
    s_d.sclk = (s_d.txs != ubgls_pkg::UBGLS_TX_SHIFT) || s_d.ph;

    if (!rx_enable || mode == ubgls_pkg::UBGLS_MODE0) begin
      s_d.rxs = ubgls_pkg::UBGLS_RX_IDLE;
    end else if (tick) begin
      s_d.rovs = s_q.rovs + 4'h1;
      case (s_q.rxs)
        ubgls_pkg::UBGLS_RX_IDLE: begin
          s_d.rovs = 4'h0;
          if (!rxd) begin
            s_d.rxs = ubgls_pkg::UBGLS_RX_START;
          end
        end
        ubgls_pkg::UBGLS_RX_START: begin
          if (s_q.rovs == ubgls_pkg::UBGLS_OVS_MID && rxd) begin
            s_d.rxs = ubgls_pkg::UBGLS_RX_IDLE;
          end else if (s_q.rovs == ubgls_pkg::UBGLS_OVS_LAST) begin
            s_d.rbit = nine ? 4'h9 : 4'h8;
            s_d.rxs = ubgls_pkg::UBGLS_RX_DATA;
          end
        end
        ubgls_pkg::UBGLS_RX_DATA: begin
          if (s_q.rovs == ubgls_pkg::UBGLS_OVS_MID) begin
            s_d.rsh = {rxd, s_q.rsh[8:1]};
          end
          if (s_q.rovs == ubgls_pkg::UBGLS_OVS_LAST) begin
            s_d.rbit = s_q.rbit - 4'h1;
            if (s_q.rbit == 4'h1) begin
              s_d.rxs = ubgls_pkg::UBGLS_RX_STOP;
            end
          end
        end
        default: begin
          if (s_q.rovs == ubgls_pkg::UBGLS_OVS_MID) begin
            // realign 8-bit data to the low bits
            rx_done = 1'b1;
            rx_word = nine ? s_q.rsh : {1'b0, s_q.rsh[8:1]};
            s_d.rxs = ubgls_pkg::UBGLS_RX_IDLE;
          end
        end
      endcase
    end
    if (rx_read) begin
      s_d.rfull = 1'b0;
    end
    s_d.rx_irq = rx_done;
    if (rx_done) begin
      s_d.rbuf = rx_word;
      s_d.rfull = 1'b1;
      if (s_q.rfull && !rx_read) begin
        s_d.rovr = 1'b1;
      end
    end

    if (!lin_autobaud) begin
      s_d.ls = ubgls_pkg::UBGLS_LIN_PREP;
    end else begin
      case (s_q.ls)
        ubgls_pkg::UBGLS_LIN_PREP: begin
          s_d.low = '0;
          s_d.edges = '0;
          s_d.ls = ubgls_pkg::UBGLS_LIN_WBRK;
        end
        ubgls_pkg::UBGLS_LIN_WBRK: begin
          if (!rxd && tick && s_q.low != 12'hfff) begin
            s_d.low = s_q.low + 12'h001;
          end
          if (rxd && !s_q.rxd_p) begin
            s_d.low = '0;
            if (s_q.low >= ubgls_pkg::UBGLS_BRK_MIN) begin
              s_d.ls = ubgls_pkg::UBGLS_LIN_MEAS;
            end
          end
        end
        default: begin
          // five falls of 55h span eight bits
          s_d.cyc = s_q.cyc + 19'h00001;
          if (fall) begin
            s_d.edges = s_q.edges + 3'h1;
            if (s_q.edges == 3'h0) begin
              s_d.cyc = 19'h00001;
            end
            if (s_d.edges == ubgls_pkg::UBGLS_SYNC_FALL) begin
              s_d.lbits = 16'(s_q.cyc >> ubgls_pkg::UBGLS_SYNC_SHR);
              s_d.ldone = 1'b1;
              s_d.ls = ubgls_pkg::UBGLS_LIN_PREP;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_q       <= '0;
      s_q.txd   <= 1'b1;
      s_q.sclk  <= 1'b1;
      s_q.rxd_p <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.d2h_txd          = s_q.txd;
  assign link.d2h_sclk         = s_q.sclk;
  assign frac_div_count_reg    = s_q.fd;
  assign divider_overflow_flag = s_q.fd_ovf;
  assign divider_irq           = s_q.fd_irq;
  assign tx_done_irq           = s_q.tx_irq;
  assign rx_data               = s_q.rbuf;
  assign rx_full               = s_q.rfull;
  assign rx_overrun            = s_q.rovr;
  assign rx_done_irq           = s_q.rx_irq;
  assign lin_sync_done         = s_q.ldone;
  assign lin_bit_cycles        = s_q.lbits;
endmodule

//--- src/ubgls_fifo.sv
// Valid/ready FIFO built from flip-flops
`timescale 1ns/100ps
module ubgls_fifo #(
  parameter int unsigned W     = 9,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic         mclk,
  input  wire logic         reset_n,
  input  wire logic         s_valid,
  input  wire logic [W-1:0] s_data,
  output logic              s_ready,
  output logic              m_valid,
  output logic [W-1:0]      m_data,
  input  wire logic         m_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
    $error("ubgls_fifo depth must be a power of two");
  end
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    full;
    logic                    empty;
  } ubgls_fifo_st_t;
  ubgls_fifo_st_t s_q, s_d;
  logic push, pop;
  always_comb begin
    s_d  = s_q;
    push = s_valid && !s_q.full;
    pop  = m_ready && !s_q.empty;
    if (push) begin
      s_d.mem[s_q.wp] = s_data;
      s_d.wp = s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 1'b1;
    end
    s_d.cnt   = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    s_d.full  = (s_d.cnt == (AW+1)'(DEPTH));
    s_d.empty = (s_d.cnt == '0);
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_q       <= '0;
      s_q.empty <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
  assign s_ready = !s_q.full;
  assign m_valid = !s_q.empty;
  assign m_data  = s_q.mem[s_q.rp];
endmodule

//--- src/ubgls_host.sv
// Remote serial node: byte frames and LIN master header
`timescale 1ns/100ps
module ubgls_host #(
  parameter int unsigned BIT_CYC = 32
) (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  ubgls_link_if.host      link,
  input  wire logic       nine_bit,
  input  wire logic       tx_valid,
  input  wire logic [8:0] tx_data,
  output logic            tx_ready,
  input  wire logic       send_header,
  input  wire logic [7:0] header_id,
  output logic            rx_valid,
  output logic      [8:0] rx_data
);
  if (BIT_CYC < 4 || BIT_CYC > 65535) begin : g_bad
    $error("ubgls_host bit period out of range");
  end
  localparam logic [15:0] BIT_LAST = 16'(BIT_CYC - 1);
  localparam logic [15:0] BIT_MID  = 16'(BIT_CYC / 2);
  typedef struct packed {
    logic        tbusy;
    logic [15:0] tcnt;
    logic [3:0]  tbit;
    logic [13:0] tsh;
    logic [1:0]  hstage;
    logic [7:0]  hid;
    logic        txd;
    logic        rbusy;
    logic [15:0] rcnt;
    logic [3:0]  rbit;
    logic [9:0]  rsh;
    logic        rvalid;
    logic [8:0]  rdata;
  } ubgls_host_st_t;
  ubgls_host_st_t s_q, s_d;

  function automatic logic [13:0] ubgls_frame(input logic nb,
                                              input logic [8:0] d);
    ubgls_frame = nb ? {4'hf, d, 1'b0} : {5'h1f, d[7:0], 1'b0};
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    if (!s_q.tbusy) begin
      s_d.tcnt = '0;
      if (s_q.hstage == 2'h1) begin
        s_d.tsh = ubgls_frame(1'b0, {1'b0, ubgls_pkg::UBGLS_SYNC_BYTE});
        s_d.tbit = ubgls_pkg::UBGLS_BITS_8;
        s_d.hstage = 2'h2;
        s_d.tbusy = 1'b1;
      end else if (s_q.hstage == 2'h2) begin
        s_d.tsh = ubgls_frame(1'b0, {1'b0, s_q.hid});
        s_d.tbit = ubgls_pkg::UBGLS_BITS_8;
        s_d.hstage = 2'h0;
        s_d.tbusy = 1'b1;
      end else if (send_header) begin
        // 13 low bits then one high
        s_d.tsh = ubgls_pkg::UBGLS_BRK_PAT;
        s_d.tbit = ubgls_pkg::UBGLS_BRK_TOTAL;
        s_d.hid = header_id;
        s_d.hstage = 2'h1;
        s_d.tbusy = 1'b1;
      end else if (tx_valid) begin
        s_d.tsh = ubgls_frame(nine_bit, tx_data);
        s_d.tbit = nine_bit ? ubgls_pkg::UBGLS_BITS_9
                            : ubgls_pkg::UBGLS_BITS_8;
        s_d.tbusy = 1'b1;
      end
    end else if (s_q.tcnt == BIT_LAST) begin
      s_d.tcnt = '0;
      s_d.tsh = {1'b1, s_q.tsh[13:1]};
      s_d.tbit = s_q.tbit - 4'h1;
      s_d.tbusy = (s_q.tbit != 4'h1);
    end else begin
      s_d.tcnt = s_q.tcnt + 16'h0001;
    end
    s_d.txd = s_d.tbusy ? s_d.tsh[0] : 1'b1;

    if (!s_q.rbusy) begin
      s_d.rcnt = '0;
      s_d.rbit = nine_bit ? ubgls_pkg::UBGLS_BITS_9 : ubgls_pkg::UBGLS_BITS_8;
      s_d.rbusy = !link.d2h_txd;
    end else if (s_q.rcnt == BIT_LAST) begin
      s_d.rcnt = '0;
    end else begin
      s_d.rcnt = s_q.rcnt + 16'h0001;
      if (s_q.rcnt == BIT_MID) begin
        s_d.rsh = {link.d2h_txd, s_q.rsh[9:1]};
        s_d.rbit = s_q.rbit - 4'h1;
        if (s_q.rbit == 4'h1) begin
          s_d.rbusy = 1'b0;
          s_d.rvalid = 1'b1;
          s_d.rdata = nine_bit ? s_q.rsh[9:1] : {1'b0, s_q.rsh[9:2]};
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_q     <= '0;
      s_q.txd <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.h2d_txd = s_q.txd;
  assign tx_ready     = !s_q.tbusy && s_q.hstage == 2'h0 && !send_header;
  assign rx_valid     = s_q.rvalid;
  assign rx_data      = s_q.rdata;
endmodule

//--- src/ubgls_link_if.sv
// Serial link between the port and its remote node
`timescale 1ns/100ps
interface ubgls_link_if;
  logic d2h_txd;
  logic d2h_sclk;
  logic h2d_txd;
  modport dev  (output d2h_txd, output d2h_sclk, input h2d_txd);
  modport host (input d2h_txd, input d2h_sclk, output h2d_txd);
endinterface

//--- src/ubgls_pkg.sv
// Shared constants and types for the serial port and its link partner
package ubgls_pkg;
  typedef enum logic [1:0] {
    UBGLS_MODE0 = 2'b00,
    UBGLS_MODE1 = 2'b01,
    UBGLS_MODE2 = 2'b10,
    UBGLS_MODE3 = 2'b11
  } ubgls_mode_t;
  typedef enum logic [1:0] {
    UBGLS_TX_IDLE  = 2'b00,
    UBGLS_TX_FRAME = 2'b01,
    UBGLS_TX_SHIFT = 2'b10
  } ubgls_tx_t;
  typedef enum logic [1:0] {
    UBGLS_RX_IDLE  = 2'b00,
    UBGLS_RX_START = 2'b01,
    UBGLS_RX_DATA  = 2'b10,
    UBGLS_RX_STOP  = 2'b11
  } ubgls_rx_t;
  typedef enum logic [1:0] {
    UBGLS_LIN_PREP = 2'b00,
    UBGLS_LIN_WBRK = 2'b01,
    UBGLS_LIN_MEAS = 2'b10
  } ubgls_lin_t;
  localparam logic [3:0]  UBGLS_OVS_LAST  = 4'hf;
  localparam logic [3:0]  UBGLS_OVS_MID   = 4'h7;
  localparam logic [3:0]  UBGLS_BITS_M0   = 4'h8;
  localparam logic [3:0]  UBGLS_BITS_8    = 4'ha;
  localparam logic [3:0]  UBGLS_BITS_9    = 4'hb;
  localparam logic [3:0]  UBGLS_BRK_BITS  = 4'hd;
  localparam logic [3:0]  UBGLS_BRK_TOTAL = 4'he;
  localparam logic [13:0] UBGLS_BRK_PAT   = 14'h2000;
  localparam logic [11:0] UBGLS_BRK_MIN   = 12'h0b0;
  localparam logic [7:0]  UBGLS_SYNC_BYTE = 8'h55;
  localparam logic [2:0]  UBGLS_SYNC_FALL = 3'h5;
  localparam int unsigned UBGLS_SYNC_SHR  = 3;
  localparam logic [1:0]  UBGLS_M2_SLOW   = 2'h3;
  localparam logic [7:0]  UBGLS_BYTE_MAX  = 8'hff;
endpackage

//--- tb/test_uart_baud_gen_lin_sync.sv
// Self-checking bench: port and remote node joined over the link
`timescale 1ns/100ps
module test_uart_baud_gen_lin_sync;
  logic        mclk, reset_n, baud_src_timer1, frac_div_enable, rx_read;
  logic        frac_div_mode_select, divider_ovf_clear, tx_valid, mon_on;
  logic        lin_master, lin_break_req, lin_autobaud, divider_irq;
  logic        divider_overflow_flag, tx_ready, tx_done_irq, rx_full;
  logic        rx_overrun, rx_done_irq, lin_sync_done, nine, h_valid;
  logic        h_ready, send_header, h_rxv;
  logic        rate_double_bit, baud_timer_run;
  logic [1:0]  mode;
  logic [2:0]  baud_prescale_field;
  logic [7:0]  baud_reload_value, frac_div_increment_reg, hdr_id, got, a;
  logic [7:0]  frac_div_count_reg;
  logic [8:0]  tx_data, rx_data, h_data, h_rxd, w;
  logic [15:0] lin_bit_cycles;
  logic [31:0] seed = 32'h5a2ed11e;
  logic [8:0]  exp_q[$];
  int          n_mismatch, checked, n_done, n_div, n_sync, c, i, n, nd;
  ubgls_link_if ubgls_link_if_inst ();
  ubgls_dev ubgls_dev_inst (.mclk, .reset_n,
    .link(ubgls_link_if_inst.dev), .mode, .rate_double_bit,
    .baud_src_timer1, .baud_timer_run, .baud_prescale_field,
    .baud_reload_value, .frac_div_enable, .frac_div_mode_select,
    .frac_div_increment_reg, .frac_div_count_reg, .divider_overflow_flag,
    .divider_ovf_clear, .divider_irq, .timer1_run(1'b1),
    .timer1_high_byte(8'hff), .tx_valid, .tx_data, .tx_ready, .lin_master,
    .lin_break_req, .tx_done_irq, .rx_enable(1'b1), .rx_data, .rx_full,
    .rx_read, .rx_overrun, .rx_done_irq, .lin_autobaud, .lin_sync_done,
    .lin_bit_cycles);
  ubgls_host #(.BIT_CYC(32)) ubgls_host_inst (.mclk, .reset_n,
    .link(ubgls_link_if_inst.host), .nine_bit(nine), .tx_valid(h_valid),
    .tx_data(h_data), .tx_ready(h_ready), .send_header,
    .header_id(hdr_id), .rx_valid(h_rxv), .rx_data(h_rxd));
  ubgls_sva #(.BIT_CYC(32)) ubgls_sva_inst (.mclk, .reset_n,
    .d2h_txd(ubgls_link_if_inst.d2h_txd),
    .d2h_sclk(ubgls_link_if_inst.d2h_sclk),
    .h2d_txd(ubgls_link_if_inst.h2d_txd));
  function automatic logic [31:0] lfsr();
    seed = {seed[30:0], ^(seed & 32'h80200003)};
    return seed;
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string s);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task test_done;
    if (n_mismatch == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Leaves valid high so back-to-back pushes never drop it
  task push(input logic [8:0] d);
    tx_valid <= 1'b1;
    tx_data <= d;
    do @(posedge mclk); while (tx_ready !== 1'b1);
  endtask
  task hsend(input logic [8:0] d);
    h_valid <= 1'b1;
    h_data <= d;
    do @(posedge mclk); while (h_ready !== 1'b1);
    h_valid <= 1'b0;
  endtask
  task wait_rx;
    do @(posedge mclk); while (rx_done_irq !== 1'b1);
    #1;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    n_done += int'(tx_done_irq === 1'b1);
    n_div += int'(divider_irq === 1'b1);
    n_sync += int'(lin_sync_done === 1'b1);
    if (h_rxv === 1'b1 && mon_on)
      chk(32'(h_rxd), 32'(exp_q.pop_front()), "remote_rx");
  end
  initial begin
    repeat (40000) @(posedge mclk);
    n_mismatch++;
    test_done;
  end
  initial begin
    {mode, baud_src_timer1, frac_div_enable, frac_div_mode_select,
     divider_ovf_clear, tx_valid, lin_master, lin_break_req, rx_read,
     lin_autobaud, nine, h_valid, send_header, baud_prescale_field,
     baud_reload_value, frac_div_increment_reg, hdr_id, tx_data, h_data,
     reset_n} = '0;
    mon_on = 1'b1;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    {rate_double_bit, baud_timer_run} <= 2'b11;
    @(posedge mclk);
    // Every setting gives 32 clocks a bit to match the remote node
    for (c = 0; c < 4; c++) begin
      mode <= (c < 2) ? 2'd1 : 2'(c);
      baud_prescale_field <= 3'(c == 1);
      baud_reload_value <= 8'(c == 0);
      baud_src_timer1 <= (c == 3);
      nine <= (c >= 2);
      @(posedge mclk);
      nd = n_done;
      n = (c == 2) ? 17 : 3;
      for (i = 0; i < n; i++) begin
        w = 9'(lfsr());
        exp_q.push_back((c >= 2) ? w : {1'b0, w[7:0]});
        push(w);
      end
      tx_valid <= 1'b0;
      @(posedge mclk);
      #1 if (c == 2) chk(32'(tx_ready), 32'h0, "fifo_full");
      wait (exp_q.size() == 0);
      repeat (64) @(posedge mclk);
      chk(32'(tx_ready), 32'h1, "fifo_empty");
      chk(n_done - nd, n, "tx_done");
    end
    // Receive two bytes unread while a frame goes out
    {mode, baud_prescale_field, baud_reload_value} <= {2'd1, 3'h0, 8'h01};
    baud_src_timer1 <= 1'b0;
    nine <= 1'b0;
    @(posedge mclk);
    w = 9'(lfsr());
    exp_q.push_back({1'b0, w[7:0]});
    push(w);
    tx_valid <= 1'b0;
    for (i = 0; i < 2; i++) begin
      a = 8'(lfsr());
      hsend({1'b0, a});
      wait_rx;
      chk(32'(rx_data[7:0]), 32'(a), "rx_data");
      chk(32'(rx_overrun), 32'(i), "rx_overrun");
    end
    rx_read <= 1'b1;
    @(posedge mclk);
    rx_read <= 1'b0;
    @(posedge mclk);
    #1 chk(32'(rx_full), 32'h0, "rx_full");
    mode <= 2'd0;
    w = 9'(lfsr()) | 9'h080;
    push(w);
    tx_valid <= 1'b0;
    fork
      for (i = 0; i < 8; i++) begin
        @(posedge ubgls_link_if_inst.d2h_sclk);
        got[i] = ubgls_link_if_inst.d2h_txd;
      end
      wait_rx;
    join
    chk(32'(got), 32'(w[7:0]), "shift_tx");
    chk(32'(rx_data[7:0]), 32'hff, "shift_rx");
    mode <= 2'd1;
    lin_autobaud <= 1'b1;
    mon_on <= 1'b0;
    for (i = 0; i < 2; i++) begin
      nd = n_sync;
      hdr_id <= 8'(lfsr());
      send_header <= 1'b1;
      @(posedge mclk);
      send_header <= 1'b0;
      wait (n_sync != nd);
      chk(32'(lin_bit_cycles), 32'd32, "bit_cycles");
      repeat (800) @(posedge mclk);
    end
    // Slave request must be ignored, master one sends
    for (i = 0; i < 2; i++) begin
      nd = n_done;
      lin_master <= 1'(i);
      lin_break_req <= 1'b1;
      @(posedge mclk);
      lin_break_req <= 1'b0;
      repeat (600) @(posedge mclk);
      chk(n_done - nd, i, "break_done");
    end
    // Overflow every 256 - 8'hfc = 4 prescaler clocks
    {frac_div_enable, frac_div_mode_select} <= 2'b11;
    frac_div_increment_reg <= 8'hfc;
    // The count climbs from zero before the first reload
    repeat (300) @(posedge mclk);
    #1 nd = n_div;
    repeat (400) @(posedge mclk);
    #1 chk(n_div - nd, 100, "div_irq");
    chk(32'(frac_div_count_reg >= 8'hfc), 32'h1, "div_count");
    chk(32'(divider_overflow_flag), 32'h1, "div_flag");
    {divider_ovf_clear, frac_div_enable} <= 2'b10;
    @(posedge mclk);
    divider_ovf_clear <= 1'b0;
    @(posedge mclk);
    #1 chk(32'(divider_overflow_flag), 32'h0, "div_flag_clr");
    test_done;
  end
endmodule

//--- tb/ubgls_sva.sv
// Link timing checks between the port and its remote node
`timescale 1ns/100ps
module ubgls_sva #(
  parameter int unsigned BIT_CYC = 32
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic d2h_txd,
  input wire logic d2h_sclk,
  input wire logic h2d_txd
);
  logic [15:0] dlo_q;
  logic [15:0] hlo_q;
  // Shift-clock lows are not bit times, so they restart the run
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dlo_q <= 16'h0000;
      hlo_q <= 16'h0000;
    end else begin
      dlo_q <= (d2h_txd || !d2h_sclk) ? 16'h0000 : dlo_q + 16'h0001;
      hlo_q <= h2d_txd ? 16'h0000 : hlo_q + 16'h0001;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence low_run(s);
    !s [*8];
  endsequence
  dev_bit_len_a: assert property ($rose(d2h_txd) && d2h_sclk |->
    dlo_q % BIT_CYC == 0) else $error("device bit length wrong");
  host_bit_len_a: assert property ($rose(h2d_txd) |->
    hlo_q % BIT_CYC == 0) else $error("remote bit length wrong");
  dev_break_len_a: assert property ($rose(d2h_txd) && d2h_sclk |->
    dlo_q <= 10 * BIT_CYC || dlo_q >= 13 * BIT_CYC)
    else $error("device low run neither frame nor break");
  host_break_len_a: assert property ($rose(h2d_txd) |->
    hlo_q <= 10 * BIT_CYC || hlo_q >= 13 * BIT_CYC)
    else $error("remote low run neither frame nor break");
  dev_start_bit_a: assert property (
    $fell(d2h_txd) && d2h_sclk && $past(d2h_sclk) |-> low_run(d2h_txd))
    else $error("device start bit too short");
  host_start_bit_a: assert property ($fell(h2d_txd) |->
    low_run(h2d_txd)) else $error("remote start bit too short");
  sclk_half_rate_a: assert property ($fell(d2h_sclk) |=> d2h_sclk)
    else $error("shift clock low longer than one cycle");
  sclk_data_hold_a: assert property ($rose(d2h_sclk) |->
    $stable(d2h_txd)) else $error("shift data moved at clock rise");
endmodule
